// >>> orc_origin_return.sv
`timescale 1ns/1ps
// Overview of operation
// - Mode 10h positive, 18h negative direction.
// - No Z: accel, decel on origin, stop.
// - No Z, slow-down on and low speed at origin: stop.
// - Z, constant start: stop after Z count.
// - Z, decel start: decel, then low speed.
// - Z count end stops pulses at once.
// - Z count equals setting plus one.
// - Z count end marks completion.
// - Clear pulse on normal completion if enabled.
// - Clear pulse on abnormal stop, not low speed.
// - Trigger plus clear-enable clears counter.
// - Trigger latches counter at origin detection.
// - Counters referenced to origin despite overrun.
// - Stop method: 0 immediate, 1 decelerate.
// - Slow-down action and latch bits govern.
// - Immediate stop: event on Z end decelerating.
// - Decel stop: event on Z end origin decel.
// - Unlatched slow-down: event on Z end.
// - Z count status defaults to setting.
// - Status counts down, reloads at zero.
// - No Z, constant start: stop on origin.
// - Config bit selects Z-phase use.
// - Config bit selects counted Z edge.
// - Config bit sets origin polarity.
module orc_origin_return (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] operating_mode_code_i,
  input wire logic [7:0] start_cmd_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic use_zphase_i,
  input wire logic zphase_rising_i,
  input wire logic origin_active_high_i,
  input wire logic [orc_pkg::ZCOUNT_W-1:0] zcount_setting_i,
  input wire logic stop_method_sel_i,
  input wire logic slowdown_action_sel_i,
  input wire logic slowdown_latch_en_i,
  input wire logic clear_pulse_on_done_en_i,
  input wire logic clear_pulse_on_error_en_i,
  input wire logic cnt1_origin_trigger_i,
  input wire logic cnt1_clear_en_i,
  input wire logic cnt2_origin_trigger_i,
  input wire logic cnt2_clear_en_i,
  input wire logic at_low_speed_i,
  input wire logic origin_sensor_in_i,
  input wire logic encoder_index_in_i,
  input wire logic slowdown_in_i,
  output logic busy_o,
  output logic direction_neg_o,
  output logic pulse_enable_o,
  output logic [1:0] speed_req_o,
  output logic deviation_clear_out_o,
  output logic cnt1_latch_o,
  output logic cnt1_clear_o,
  output logic cnt2_latch_o,
  output logic cnt2_clear_o,
  output logic zcount_event_flag_o,
  output logic [orc_pkg::ZCOUNT_W-1:0] zcount_status_o,
  output logic done_o,
  output logic error_stop_o
);

  typedef struct packed {
    // Sequencer phase, what the accepted start asked for, and what slowed the run.
    orc_pkg::orc_state_t fsm;
    logic zmode;
    logic decel_start;
    logic ramp_start;
    logic decel_by_origin;
    logic decel_by_slowdown;
    logic slowdown_latched;
    // Previous synced levels, kept for edge detection, and whether the origin edge was seen.
    logic origin_prev;
    logic origin_seen;
    logic index_prev;
    // Everything below except clear_cnt drives an output port directly.
    logic direction_neg;
    logic [1:0] speed;
    logic pulse_en;
    logic [orc_pkg::ZCOUNT_W-1:0] zcount;
    logic [7:0] clear_cnt;
    logic clear_out;
    logic cnt1_latch;
    logic cnt1_clear;
    logic cnt2_latch;
    logic cnt2_clear;
    logic zevent;
    logic done;
    logic err;
  } orc_state_s_t;

  orc_state_s_t state;
  orc_state_s_t next_state;

  logic origin_sync;
  logic index_sync;
  logic slowdown_sync;
  logic origin_on;
  logic index_edge;
  logic origin_edge;
  logic slowdown_on;
  logic start_ok;
  logic zcount_end;
  logic zpulse_ok;
  logic zevent_cause;

  orc_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i({origin_sensor_in_i, encoder_index_in_i, slowdown_in_i}),
    .sync_o({origin_sync, index_sync, slowdown_sync})
  );

  // Both decelerating starts share the origin-edge slow-down path.
  function automatic logic is_decel_cmd(input logic [7:0] cmd);
    is_decel_cmd = (cmd == orc_pkg::CMD_HIGH_DECEL) || (cmd == orc_pkg::CMD_ACCEL_DECEL);
  endfunction

  // Only the two origin return codes start this sequencer; other modes belong elsewhere.
  function automatic logic is_home_mode(input logic [7:0] mode);
    is_home_mode = (mode == orc_pkg::MODE_HOME_POS) || (mode == orc_pkg::MODE_HOME_NEG);
  endfunction

  function automatic logic is_start_cmd(input logic [7:0] cmd);
    is_start_cmd = (cmd >= orc_pkg::CMD_CONST_LOW) && (cmd <= orc_pkg::CMD_ACCEL_DECEL);
  endfunction

  function automatic logic [1:0] speed_for_cmd(input logic [7:0] cmd);
    unique case (cmd)
      orc_pkg::CMD_CONST_LOW: speed_for_cmd = orc_pkg::ORC_SPD_LOW;
      orc_pkg::CMD_CONST_HIGH: speed_for_cmd = orc_pkg::ORC_SPD_HIGH;
      orc_pkg::CMD_HIGH_DECEL: speed_for_cmd = orc_pkg::ORC_SPD_HIGH;
      default: speed_for_cmd = orc_pkg::ORC_SPD_RAMP;
    endcase
  endfunction

  // Completion and abnormal stop arm the same pulse, so its width cannot drift apart.
  function automatic orc_state_s_t arm_clear(input orc_state_s_t s);
    arm_clear = s;
    arm_clear.clear_cnt = orc_pkg::CLEAR_PULSE_CYC_W;
    arm_clear.clear_out = 1'b1;
  endfunction

  always_comb begin
    // Origin and Z-phase polarity selection.
    origin_on = origin_sync ~^ origin_active_high_i;
    origin_edge = origin_on && !state.origin_prev;
    // Both edges come from the same synced copy, so the chosen edge is seen exactly once.
    if (zphase_rising_i) begin
      index_edge = index_sync && !state.index_prev;
    end else begin
      index_edge = !index_sync && state.index_prev;
    end
    slowdown_on = slowdown_sync || state.slowdown_latched;
    start_ok = start_i && is_home_mode(operating_mode_code_i) && is_start_cmd(start_cmd_i);
    // Z pulses count only after the origin edge has been seen.
    zpulse_ok = state.zmode && state.origin_seen && index_edge;
    zcount_end = zpulse_ok && (state.zcount == '0);
    // Event causes only matter while the speed is still above low speed.
    zevent_cause = !stop_method_sel_i || state.decel_by_origin
                || (state.decel_by_slowdown && !slowdown_latch_en_i);

    next_state = state;
    next_state.origin_prev = origin_on;
    next_state.index_prev = index_sync;
    next_state.cnt1_latch = 1'b0;
    next_state.cnt1_clear = 1'b0;
    next_state.cnt2_latch = 1'b0;
    next_state.cnt2_clear = 1'b0;
    next_state.zevent = 1'b0;
    next_state.done = 1'b0;
    next_state.err = 1'b0;
    // The clear pulse runs on its own counter so a new start does not cut it short.
    if (state.clear_cnt != '0) begin
      next_state.clear_cnt = state.clear_cnt - 8'h01;
    end
    next_state.clear_out = (state.clear_cnt > 8'h01);

    // Latch and clear at the origin instant; counters stay origin referenced even on overrun.
    if (state.fsm == orc_pkg::ORC_SEEK && origin_edge) begin
      next_state.cnt1_latch = cnt1_origin_trigger_i;
      next_state.cnt2_latch = cnt2_origin_trigger_i;
      next_state.cnt1_clear = cnt1_origin_trigger_i && cnt1_clear_en_i;
      next_state.cnt2_clear = cnt2_origin_trigger_i && cnt2_clear_en_i;
      next_state.origin_seen = 1'b1;
    end

    // A pulse in idle or done belongs to no run and must not disturb the reloaded status.
    if (zpulse_ok && state.fsm != orc_pkg::ORC_IDLE && state.fsm != orc_pkg::ORC_DONE) begin
      if (state.zcount == '0) begin
        next_state.zcount = zcount_setting_i;
      end else begin
        next_state.zcount = state.zcount - 4'h1;
      end
    end

    if (state.ramp_start && state.speed == orc_pkg::ORC_SPD_RAMP && state.fsm == orc_pkg::ORC_SEEK
        && !state.decel_by_slowdown) begin
      next_state.speed = orc_pkg::ORC_SPD_RAMP;
    end

    if (slowdown_sync && slowdown_latch_en_i && state.pulse_en) begin
      next_state.slowdown_latched = 1'b1;
    end

    unique case (state.fsm)
      orc_pkg::ORC_IDLE: begin
        next_state.zcount = zcount_setting_i;
        next_state.direction_neg = (operating_mode_code_i == orc_pkg::MODE_HOME_NEG);
        if (start_ok) begin
          next_state.fsm = orc_pkg::ORC_SEEK;
          next_state.zmode = use_zphase_i;
          next_state.decel_start = is_decel_cmd(start_cmd_i);
          next_state.ramp_start = (start_cmd_i == orc_pkg::CMD_ACCEL_DECEL);
          next_state.pulse_en = 1'b1;
          next_state.origin_seen = 1'b0;
          next_state.decel_by_origin = 1'b0;
          next_state.decel_by_slowdown = 1'b0;
          next_state.slowdown_latched = 1'b0;
          next_state.speed = speed_for_cmd(start_cmd_i);
        end
      end
      // Running towards the origin; the slow-down pin may already cut the speed.
      orc_pkg::ORC_SEEK: begin
        if (state.decel_start && slowdown_on && !slowdown_action_sel_i) begin
          next_state.speed = orc_pkg::ORC_SPD_LOW;
          next_state.decel_by_slowdown = 1'b1;
        end
        if (origin_edge) begin
          if (!state.decel_start) begin
            if (state.zmode) begin
              next_state.fsm = orc_pkg::ORC_ZWAIT;
            end else begin
              next_state.fsm = orc_pkg::ORC_DONE;
              next_state.pulse_en = 1'b0;
            end
          end else if (!state.zmode && !stop_method_sel_i) begin
            // Immediate stop overruns the origin but counters were referenced at the edge.
            next_state.fsm = orc_pkg::ORC_DONE;
            next_state.pulse_en = 1'b0;
          end else if (!state.zmode && slowdown_on && at_low_speed_i) begin
            next_state.fsm = orc_pkg::ORC_DONE;
            next_state.pulse_en = 1'b0;
          end else begin
            next_state.fsm = orc_pkg::ORC_DECEL;
            next_state.speed = orc_pkg::ORC_SPD_LOW;
            next_state.decel_by_origin = 1'b1;
          end
        end
      end
      // Past the origin and slowing; a Z count end here stops without waiting for low speed.
      orc_pkg::ORC_DECEL: begin
        if (state.zmode) begin
          if (zcount_end) begin
            next_state.fsm = orc_pkg::ORC_DONE;
            next_state.pulse_en = 1'b0;
            if (!at_low_speed_i) begin
              next_state.zevent = zevent_cause;
            end
          end else if (at_low_speed_i) begin
            next_state.fsm = orc_pkg::ORC_ZWAIT;
          end
        end else if (at_low_speed_i) begin
          next_state.fsm = orc_pkg::ORC_DONE;
          next_state.pulse_en = 1'b0;
        end
      end
      // Constant speed until the programmed number of Z pulses has passed.
      orc_pkg::ORC_ZWAIT: begin
        if (zcount_end) begin
          next_state.fsm = orc_pkg::ORC_DONE;
          next_state.pulse_en = 1'b0;
        end
      end
      // Pulses have stopped; report once and return to idle.
      orc_pkg::ORC_DONE: begin
        next_state.fsm = orc_pkg::ORC_IDLE;
        next_state.speed = orc_pkg::ORC_SPD_STOP;
        next_state.done = 1'b1;
        if (clear_pulse_on_done_en_i) begin
          next_state = arm_clear(next_state);
        end
      end
    endcase

    // An abnormal stop overrides any state but idle; the clear pulse is withheld at low speed.
    if (abort_i && state.fsm != orc_pkg::ORC_IDLE) begin
      next_state.fsm = orc_pkg::ORC_IDLE;
      next_state.pulse_en = 1'b0;
      next_state.speed = orc_pkg::ORC_SPD_STOP;
      next_state.zcount = zcount_setting_i;
      next_state.done = 1'b0;
      next_state.err = 1'b1;
      next_state.zevent = 1'b0;
      if (clear_pulse_on_error_en_i && !at_low_speed_i) begin
        next_state = arm_clear(next_state);
      end
    end
  end

  // Reset leaves the status at zero; idle loads the setting on the next edge.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= '0;
      state.fsm <= orc_pkg::ORC_IDLE;
      state.zcount <= orc_pkg::ZCOUNT_RST;
    end else begin
      state <= next_state;
    end
  end

  // Every output except busy_o is a copy of a state bit, so none of those can glitch.
  assign busy_o = (state.fsm != orc_pkg::ORC_IDLE);
  assign direction_neg_o = state.direction_neg;
  assign pulse_enable_o = state.pulse_en;
  assign speed_req_o = state.speed;
  assign deviation_clear_out_o = state.clear_out;
  assign cnt1_latch_o = state.cnt1_latch;
  assign cnt1_clear_o = state.cnt1_clear;
  assign cnt2_latch_o = state.cnt2_latch;
  assign cnt2_clear_o = state.cnt2_clear;
  assign zcount_event_flag_o = state.zevent;
  assign zcount_status_o = state.zcount;
  assign done_o = state.done;
  assign error_stop_o = state.err;

endmodule

// >>> orc_pkg.sv
package orc_pkg;

  localparam logic [7:0] MODE_HOME_POS = 8'h10;
  localparam logic [7:0] MODE_HOME_NEG = 8'h18;
  localparam logic [7:0] CMD_CONST_LOW = 8'h50;
  localparam logic [7:0] CMD_CONST_HIGH = 8'h51;
  localparam logic [7:0] CMD_HIGH_DECEL = 8'h52;
  localparam logic [7:0] CMD_ACCEL_DECEL = 8'h53;

  localparam int ZCOUNT_W = 4;
  localparam logic [3:0] ZCOUNT_RST = 4'h0;

  // Width of the deviation-clear ON pulse.
  localparam int CLEAR_PULSE_NS = 100;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CLEAR_PULSE_CYC_W = 8'(CLEAR_PULSE_CYC);

  typedef enum logic [4:0] {
    ORC_IDLE = 5'b00001,
    ORC_SEEK = 5'b00010,
    ORC_DECEL = 5'b00100,
    ORC_ZWAIT = 5'b01000,
    ORC_DONE = 5'b10000
  } orc_state_t;

  typedef enum logic [1:0] {
    ORC_SPD_STOP = 2'h0,
    ORC_SPD_LOW = 2'h1,
    ORC_SPD_HIGH = 2'h2,
    ORC_SPD_RAMP = 2'h3
  } orc_speed_t;

endpackage

// >>> orc_sync.sv
`timescale 1ns/1ps
module orc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } orc_sync_state_t;

  orc_sync_state_t state;
  orc_sync_state_t next_state;

  always_comb begin
    next_state.stage1 = async_i;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_o = state.stage2;

endmodule

// >>> orc_checker_assertions.sv
`timescale 1ns/1ps
module orc_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] operating_mode_code_i,
  input wire logic [7:0] start_cmd_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [3:0] zcount_setting_i,
  input wire logic clear_pulse_on_done_en_i,
  input wire logic cnt1_origin_trigger_i,
  input wire logic cnt1_clear_en_i,
  input wire logic busy_o,
  input wire logic direction_neg_o,
  input wire logic pulse_enable_o,
  input wire logic [1:0] speed_req_o,
  input wire logic deviation_clear_out_o,
  input wire logic cnt1_clear_o,
  input wire logic zcount_event_flag_o,
  input wire logic [3:0] zcount_status_o,
  input wire logic done_o,
  input wire logic error_stop_o
);
  logic go;
  logic [7:0] wid;
  assign go = start_i && !busy_o && operating_mode_code_i[7:4] == 4'h1
    && operating_mode_code_i[2:0] == 3'h0 && start_cmd_i[7:2] == 6'h14;
  // Width of the clear pulse so far, judged at its falling edge.
  always_ff @(posedge sys_clk_i) begin
    wid <= (rst_i || !deviation_clear_out_o) ? 8'h00 : wid + 8'h01;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_start;
    go |=> busy_o && pulse_enable_o;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_dir;
    go |=> direction_neg_o == $past(operating_mode_code_i[3]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_spd;
    go |=> speed_req_o == 2'h1 + $past(start_cmd_i[0]) + $past(start_cmd_i[1]);
  endproperty
  a_spd: assert property (p_spd) else $error("speed request wrong");
  property p_wid;
    $fell(deviation_clear_out_o) |-> wid == orc_pkg::CLEAR_PULSE_CYC_W;
  endproperty
  a_wid: assert property (p_wid) else $error("clear pulse width wrong");
  property p_clr;
    done_o && clear_pulse_on_done_en_i |-> ##[0:1] deviation_clear_out_o;
  endproperty
  a_clr: assert property (p_clr) else $error("no clear pulse on done");
  property p_ab;
    abort_i && pulse_enable_o |-> ##[1:4] error_stop_o;
  endproperty
  a_ab: assert property (p_ab) else $error("abort not reported");
  property p_done;
    done_o |-> !busy_o && !pulse_enable_o && zcount_status_o == zcount_setting_i;
  endproperty
  a_done: assert property (p_done) else $error("done state wrong");
  property p_c1;
    cnt1_clear_o |-> cnt1_origin_trigger_i && cnt1_clear_en_i;
  endproperty
  a_c1: assert property (p_c1) else $error("counter clear unwanted");
  property p_ev;
    zcount_event_flag_o |-> ##[0:2] done_o;
  endproperty
  a_ev: assert property (p_ev) else $error("event without stop");
endmodule
bind orc_origin_return orc_checker u_chk (.*);

// >>> orc_far_model.sv
`timescale 1ns/1ps
module orc_far_model #(
  parameter int ORG = 40,
  parameter int ZP = 16,
  parameter int DEC = 30
) (
  input wire logic sys_clk_i,
  input wire logic pulse_enable_i,
  input wire logic [1:0] speed_req_i,
  input wire logic origin_active_high_i,
  input wire logic zphase_rising_i,
  output logic origin_sensor_in_o,
  output logic encoder_index_in_o,
  output logic at_low_speed_o
);
  int pos = 0;
  int low = 0;
  // Travel restarts each run, and index marks also occur before the origin.
  always @(posedge sys_clk_i) begin
    pos <= pulse_enable_i ? pos + 1 : 0;
    low <= (pos >= ORG || speed_req_i == 2'h1) ? low + 1 : 0;
  end
  assign origin_sensor_in_o = (pos >= ORG) ~^ origin_active_high_i;
  assign encoder_index_in_o = ((pos % ZP) >= ZP - 3) ~^ zphase_rising_i;
  assign at_low_speed_o = low >= DEC;
endmodule

// >>> origin_return_control_test.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module origin_return_control_test;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] operating_mode_code_i = 8'h10;
  logic [7:0] start_cmd_i = 8'h50;
  logic start_i = 1'b0, abort_i = 1'b0, use_zphase_i = 1'b0, zphase_rising_i = 1'b1;
  logic origin_active_high_i = 1'b1, stop_method_sel_i = 1'b0, slowdown_action_sel_i = 1'b0;
  logic slowdown_latch_en_i = 1'b0, clear_pulse_on_done_en_i = 1'b1, clear_pulse_on_error_en_i = 1'b1;
  logic cnt1_origin_trigger_i = 1'b0, cnt1_clear_en_i = 1'b0, cnt2_origin_trigger_i = 1'b0;
  logic cnt2_clear_en_i = 1'b0, slowdown_in_i = 1'b0;
  logic [3:0] zcount_setting_i = 4'h1;
  logic at_low_speed_i, origin_sensor_in_i, encoder_index_in_i;
  logic busy_o, direction_neg_o, pulse_enable_o, deviation_clear_out_o, done_o, error_stop_o;
  logic cnt1_latch_o, cnt1_clear_o, cnt2_latch_o, cnt2_clear_o, zcount_event_flag_o;
  logic [1:0] speed_req_o;
  logic [3:0] zcount_status_o;
  int err_count = 0, checked = 0, cyc = 0, zc, n_dev, n_l1, n_c1, n_l2, n_c2, n_ev;
  logic zprev = 1'b0, fin_done, fin_err;
  logic [3:0] zmin;
  logic [1:0] spd_mid;
  wire zact = encoder_index_in_i ~^ zphase_rising_i;

  orc_origin_return DUT (.*);
  orc_far_model FAR (.sys_clk_i(sys_clk_i), .pulse_enable_i(pulse_enable_o), .speed_req_i(speed_req_o),
    .origin_active_high_i(origin_active_high_i), .zphase_rising_i(zphase_rising_i),
    .origin_sensor_in_o(origin_sensor_in_i), .encoder_index_in_o(encoder_index_in_i),
    .at_low_speed_o(at_low_speed_i));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
    n_dev += deviation_clear_out_o;
    n_l1 += cnt1_latch_o;
    n_c1 += cnt1_clear_o;
    n_l2 += cnt2_latch_o;
    n_c2 += cnt2_clear_o;
    n_ev += zcount_event_flag_o;
    if (busy_o && (origin_sensor_in_i ~^ origin_active_high_i) && zact && !zprev) zc++;
    if (busy_o && zcount_status_o < zmin) zmin = zcount_status_o;
    zprev = zact;
  end

  task automatic run(input logic [7:0] m, input logic [7:0] c, input int ab);
    int t;
    operating_mode_code_i = m;
    start_cmd_i = c;
    {zc, n_dev, n_l1, n_c1, n_l2, n_c2, n_ev} = '0;
    zmin = 4'hf;
    fin_done = 1'b0;
    fin_err = 1'b0;
    @(posedge sys_clk_i);
    #1 start_i = 1'b1;
    @(posedge sys_clk_i);
    #1 start_i = 1'b0;
    `CHK("busy", 1'b1, busy_o)
    `CHK("direction", m[3], direction_neg_o)
    `CHK("speed", 2'h1 + c[0] + c[1], speed_req_o)
    t = 0;
    while (!fin_done && !fin_err && t < 600) begin
      abort_i = (t == ab);
      @(posedge sys_clk_i);
      #1 t++;
      fin_done = done_o === 1'b1;
      fin_err = error_stop_o === 1'b1;
      if (t == 20) spd_mid = speed_req_o;
    end
    abort_i = 1'b0;
    repeat (24) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic t_plain();
    for (int i = 0; i < 8; i++) begin
      origin_active_high_i = !i[2];
      stop_method_sel_i = i[0];
      cnt1_origin_trigger_i = i[0];
      cnt1_clear_en_i = i[1];
      cnt2_origin_trigger_i = !i[0];
      cnt2_clear_en_i = 1'b1;
      run(i[2] ? 8'h18 : 8'h10, {6'h14, i[1:0]}, -1);
      `CHK("done", 1'b1, fin_done)
      `CHK("latch1", i[0], n_l1)
      `CHK("clear1", i[0] & i[1], n_c1)
      `CHK("latch2", !i[0], n_l2)
      `CHK("clear2", !i[0], n_c2)
      `CHK("clrpulse", orc_pkg::CLEAR_PULSE_CYC, n_dev)
    end
    $display("plain origin return finished");
  endtask

  task automatic t_zphase();
    use_zphase_i = 1'b1;
    origin_active_high_i = 1'b1;
    for (int i = 0; i < 2; i++) begin
      zphase_rising_i = i[0];
      zcount_setting_i = i[0] ? 4'h3 : 4'h1;
      run(8'h10, i[0] ? 8'h50 : 8'h51, -1);
      `CHK("zdone", 1'b1, fin_done)
      `CHK("zcount", zcount_setting_i + 1, zc)
      `CHK("zmin", 4'h0, zmin)
      `CHK("zreload", zcount_setting_i, zcount_status_o)
    end
    $display("index count return finished");
  endtask

  task automatic t_event();
    for (int i = 0; i < 3; i++) begin
      stop_method_sel_i = (i != 0);
      zcount_setting_i = (i == 2) ? 4'h3 : 4'h0;
      run(8'h18, 8'h53, -1);
      `CHK("zdone", 1'b1, fin_done)
      `CHK("zevent", i != 2, n_ev)
    end
    $display("index event finished");
  endtask

  task automatic t_slow();
    slowdown_in_i = 1'b1;
    stop_method_sel_i = 1'b1;
    slowdown_action_sel_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      use_zphase_i = i[0];
      zcount_setting_i = 4'h0;
      run(8'h10, 8'h53, -1);
      `CHK("sdspeed", 2'h1, spd_mid)
      `CHK("sddone", 1'b1, fin_done)
      `CHK("sdevent", 0, n_ev)
    end
    slowdown_in_i = 1'b0;
    $display("slow-down return finished");
  endtask

  task automatic t_abort();
    use_zphase_i = 1'b0;
    for (int i = 0; i < 3; i++) begin
      clear_pulse_on_error_en_i = (i != 1);
      run(8'h10, i == 2 ? 8'h50 : 8'h51, i == 2 ? 34 : 5);
      `CHK("errstop", 1'b1, fin_err)
      `CHK("errpulse", i == 0 ? orc_pkg::CLEAR_PULSE_CYC : 0, n_dev)
    end
    $display("abnormal stop finished");
  endtask

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    t_plain();
    t_zphase();
    t_event();
    t_slow();
    t_abort();
    close_out();
  end
endmodule
